// ### rtl/cios_top.v
// Subdevice configuration select, frequency channels, output protection and pattern events
// How it works
// R1: Alternative input config gives eight channels measuring period and high time.
// R2: Alternative output config gives eight channels generating programmable rectangular waves.
// R3: Configuration saved to non-volatile store, reloaded at restart, default plain.
// R4: Host changes configuration only before the application starts.
// R5: Channels not used by frequency functions are unavailable for digital use.
// R6: Unused upper outputs float with sink drivers, drive ground with source drivers.
// R7: Each source-driven port raises an interrupt on overload.
// R8: A source-driven port with missing ground is disabled entirely.
// R9: Pattern change or compare events on inputs interrupt the host, up to 10 kHz.
// R10: One selector per subdevice routes pins to plain or frequency path.
`include "cios_defs.vh"
module cios_top #(
  parameter NCH = `CIOS_NCH,
  parameter NP  = `CIOS_NPORT,
  parameter CW  = 32,
  parameter IRQ_GAP = `CIOS_IRQ_GAP_CYC
)(
  // Clock and reset
  input  wire              clk_sys,
  input  wire              arst_n,
  // Non-volatile configuration store
  input  wire              nv_valid,
  input  wire              nv_in_cfg,
  input  wire              nv_out_cfg,
  output reg               nv_wr_reg,
  output reg               nv_in_cfg_reg,
  output reg               nv_out_cfg_reg,
  // Host configuration control
  input  wire              cfg_wr,
  input  wire              cfg_in_sel,
  input  wire              cfg_out_sel,
  input  wire              app_running,
  output reg               in_alt_reg,
  output reg               out_alt_reg,
  // Input pins
  input  wire [NP-1:0]     din_pin,
  output reg  [NP-1:0]     din_val_reg,
  // Frequency measurement results
  output reg  [NCH*CW-1:0] fm_period_reg,
  output reg  [NCH*CW-1:0] fm_high_reg,
  output reg  [NCH-1:0]    fm_done_reg,
  // Pulse generator setup
  input  wire [NCH*CW-1:0] pg_period,
  input  wire [NCH*CW-1:0] pg_high,
  input  wire [NCH-1:0]    pg_start_low,
  input  wire [NCH-1:0]    pg_enable,
  // Plain outputs and driver control
  input  wire [NP-1:0]     dout_val,
  input  wire [1:0]        src_sel,
  input  wire [1:0]        port_hiz,
  input  wire [1:0]        gnd_ok_pin,
  input  wire [1:0]        ovl_pin,
  output reg  [NP-1:0]     dout_pin_reg,
  output reg  [NP-1:0]     dout_oe_reg,
  output reg  [1:0]        ovl_irq_reg,
  // Pattern event control
  input  wire              pat_en,
  input  wire              pat_mode,
  input  wire [2*NP-1:0]   pat_edge_mask,
  input  wire [NP-1:0]     pat_cmp_mask,
  input  wire [NP-1:0]     pat_ref,
  output reg               pat_irq_reg,
  output reg  [2*NP-1:0]   pat_status_reg
);
  // ==========================================================
  // Input synchronisers
  reg  [NP-1:0] din_s1_reg, din_s2_reg, din_prev_reg;
  reg  [1:0]    gnd_s1_reg, gnd_s2_reg, ovl_s1_reg, ovl_s2_reg, ovl_prev_reg;
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      din_s1_reg   <= {NP{1'b0}};
      din_s2_reg   <= {NP{1'b0}};
      din_prev_reg <= {NP{1'b0}};
      gnd_s1_reg   <= 2'h0;
      gnd_s2_reg   <= 2'h0;
      ovl_s1_reg   <= 2'h0;
      ovl_s2_reg   <= 2'h0;
      ovl_prev_reg <= 2'h0;
    end
    else
    begin
      din_s1_reg   <= din_pin;
      din_s2_reg   <= din_s1_reg;
      din_prev_reg <= din_s2_reg;
      gnd_s1_reg   <= gnd_ok_pin;
      gnd_s2_reg   <= gnd_s1_reg;
      ovl_s1_reg   <= ovl_pin;
      ovl_s2_reg   <= ovl_s1_reg;
      ovl_prev_reg <= ovl_s2_reg;
    end
  end

  // ==========================================================
  // Configuration selectors
  // Store contents arrive after reset; caught by clock, never by the reset itself
  reg loaded_reg;
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      in_alt_reg     <= `CIOS_CFG_RESET;
      out_alt_reg    <= `CIOS_CFG_RESET;
      loaded_reg     <= 1'b0;
      nv_wr_reg      <= 1'b0;
      nv_in_cfg_reg  <= `CIOS_CFG_RESET;
      nv_out_cfg_reg <= `CIOS_CFG_RESET;
    end
    else
    begin
      nv_wr_reg <= 1'b0;
      if (!loaded_reg && nv_valid)
      begin
        in_alt_reg  <= nv_in_cfg; // R3
        out_alt_reg <= nv_out_cfg;
        loaded_reg  <= 1'b1;
      end
      else if (loaded_reg && cfg_wr && !app_running) // R4
      begin
        in_alt_reg     <= cfg_in_sel; // R10
        out_alt_reg    <= cfg_out_sel;
        nv_wr_reg      <= 1'b1; // R3
        nv_in_cfg_reg  <= cfg_in_sel;
        nv_out_cfg_reg <= cfg_out_sel;
      end
    end
  end

  // ==========================================================
  // Frequency measurement and pulse generation
  reg [CW-1:0] fm_cnt_reg  [0:NCH-1];
  reg [CW-1:0] fm_hi_reg   [0:NCH-1];
  reg [NCH-1:0] fm_arm_reg;
  reg [CW-1:0] pg_cnt_reg  [0:NCH-1];
  reg [NCH-1:0] pg_out_reg;
  integer i;
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fm_arm_reg    <= {NCH{1'b0}};
      fm_done_reg   <= {NCH{1'b0}};
      fm_period_reg <= {NCH*CW{1'b0}};
      fm_high_reg   <= {NCH*CW{1'b0}};
      pg_out_reg    <= {NCH{1'b0}};
      for (i = 0; i < NCH; i = i + 1)
      begin
        fm_cnt_reg[i] <= {CW{1'b0}};
        fm_hi_reg[i]  <= {CW{1'b0}};
        pg_cnt_reg[i] <= {CW{1'b0}};
      end
    end
    else
    begin
      fm_done_reg <= {NCH{1'b0}};
      for (i = 0; i < NCH; i = i + 1)
      begin
        // Measurement runs rising edge to rising edge
        if (!in_alt_reg)
          fm_arm_reg[i] <= 1'b0;
        else if (din_s2_reg[i] && !din_prev_reg[i]) // R1
        begin
          if (fm_arm_reg[i])
          begin
            fm_period_reg[i*CW +: CW] <= fm_cnt_reg[i];
            fm_high_reg[i*CW +: CW]   <= fm_hi_reg[i];
            fm_done_reg[i]            <= 1'b1;
          end
          fm_arm_reg[i] <= 1'b1;
          fm_cnt_reg[i] <= {{(CW-1){1'b0}}, 1'b1};
          fm_hi_reg[i]  <= {{(CW-1){1'b0}}, 1'b1};
        end
        else
        begin
          fm_cnt_reg[i] <= fm_cnt_reg[i] + 1'b1;
          if (din_s2_reg[i])
            fm_hi_reg[i] <= fm_hi_reg[i] + 1'b1;
        end
        // Generator: first phase for pg_high ticks, then second phase
        if (!out_alt_reg || !pg_enable[i])
        begin
          pg_cnt_reg[i] <= {CW{1'b0}};
          pg_out_reg[i] <= 1'b0;
        end
        else // R2
        begin
          if (pg_cnt_reg[i] + 1'b1 >= pg_period[i*CW +: CW])
            pg_cnt_reg[i] <= {CW{1'b0}};
          else
            pg_cnt_reg[i] <= pg_cnt_reg[i] + 1'b1;
          pg_out_reg[i] <= (pg_cnt_reg[i] < pg_high[i*CW +: CW]) ^ pg_start_low[i];
        end
      end
    end
  end

  // ==========================================================
  // Output drive, port protection, overload events
  reg [NP-1:0] drv_val, drv_oe;
  integer p;
  always @*
  begin
    drv_val = out_alt_reg ? {{(NP-NCH){1'b0}}, pg_out_reg} : dout_val; // R5 R10
    drv_oe  = {NP{1'b1}};
    for (p = 0; p < 2; p = p + 1)
    begin
      if (port_hiz[p] || (src_sel[p] && !gnd_s2_reg[p])) // R8
        drv_oe[p*8 +: 8] = 8'h00;
      // Sink: upper outputs float; source: drive ground
      if (out_alt_reg && p == 1 && !src_sel[p]) // R6
        drv_oe[p*8 +: 8] = 8'h00;
    end
  end

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dout_pin_reg <= {NP{1'b0}};
      dout_oe_reg  <= {NP{1'b0}};
      ovl_irq_reg  <= 2'h0;
      din_val_reg  <= {NP{1'b0}};
    end
    else
    begin
      dout_pin_reg <= drv_val;
      dout_oe_reg  <= drv_oe;
      ovl_irq_reg  <= src_sel & ovl_s2_reg & ~ovl_prev_reg; // R7
      // Frequency inputs hide the shared pins from the plain path
      din_val_reg  <= in_alt_reg ? {NP{1'b0}} : din_s2_reg; // R5
    end
  end

  // ==========================================================
  // Pattern change / compare events
  wire [NP-1:0] rise = din_s2_reg & ~din_prev_reg;
  wire [NP-1:0] fall = ~din_s2_reg & din_prev_reg;
  wire [2*NP-1:0] hit = {rise, fall} & pat_edge_mask;
  wire cmp_now  = ((din_s2_reg ^ pat_ref) & pat_cmp_mask) == {NP{1'b0}};
  wire cmp_prev = ((din_prev_reg ^ pat_ref) & pat_cmp_mask) == {NP{1'b0}};
  wire pat_evt  = pat_mode ? (cmp_now != cmp_prev) : (|hit);
  // Minimum spacing caps event rate at the supported 10 kHz
  reg [31:0] gap_reg;
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gap_reg        <= 32'h0;
      pat_irq_reg    <= 1'b0;
      pat_status_reg <= {2*NP{1'b0}};
    end
    else
    begin
      pat_irq_reg <= 1'b0;
      if (gap_reg != 32'h0)
        gap_reg <= gap_reg - 32'h1;
      if (pat_en && !in_alt_reg && pat_evt && gap_reg == 32'h0) // R9
      begin
        pat_irq_reg    <= 1'b1;
        pat_status_reg <= pat_mode ? {2*NP{1'b0}} : hit;
        gap_reg        <= IRQ_GAP;
      end
    end
  end
endmodule

// ### rtl/cios_defs.vh
// Constants for the configurable I/O subdevice select block
`ifndef CIOS_DEFS_VH
`define CIOS_DEFS_VH
`define CIOS_CFG_PLAIN      1'b0
`define CIOS_CFG_ALT        1'b1
`define CIOS_CFG_RESET      1'b0
`define CIOS_NCH            8
`define CIOS_NPORT          16
`define CIOS_MODE_CHANGE    1'b0
`define CIOS_MODE_COMPARE   1'b1
`define CIOS_IRQ_MIN_NS     100000
`define CIOS_CLK_NS         20
`define CIOS_IRQ_GAP_CYC    (`CIOS_IRQ_MIN_NS / `CIOS_CLK_NS)
`define CIOS_FREQ_MAX_KHZ   300
`define CIOS_PULSE_MAX_KHZ  3
`endif

// ### sim/cios_nvmem.sv
// Model of the non-volatile selector store behind the block
module cios_nvmem (
  input wire logic clk_sys,
  input wire logic nv_wr_reg,
  input wire logic nv_in_cfg_reg,
  input wire logic nv_out_cfg_reg,
  output logic     nv_in_cfg,
  output logic     nv_out_cfg
);
  timeunit 1ns;
  timeprecision 1ns;
  // No reset on purpose: contents must survive a restart
  initial {nv_in_cfg, nv_out_cfg} = 2'b00;
  always @(posedge clk_sys)
    if (nv_wr_reg)
      {nv_in_cfg, nv_out_cfg} <= {nv_in_cfg_reg, nv_out_cfg_reg};
endmodule

// ### sim/cios_asserts.sv
// Checker for selector, output protection and pattern event behaviour
module cios_asserts #(
  parameter NP = 16
) (
  // Clock and reset
  input wire logic          clk_sys,
  input wire logic          arst_n,
  // Configuration
  input wire logic          nv_valid,
  input wire logic          cfg_wr,
  input wire logic          cfg_in_sel,
  input wire logic          cfg_out_sel,
  input wire logic          app_running,
  input wire logic          in_alt_reg,
  input wire logic          out_alt_reg,
  // Pins and events
  input wire logic [NP-1:0] din_val_reg,
  input wire logic [NP-1:0] dout_pin_reg,
  input wire logic [NP-1:0] dout_oe_reg,
  input wire logic [1:0]    src_sel,
  input wire logic [1:0]    gnd_ok_pin,
  input wire logic [1:0]    ovl_pin,
  input wire logic [1:0]    ovl_irq_reg,
  input wire logic          pat_irq_reg
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  a_cfg_taken: assert property (cfg_wr && !app_running && $past(nv_valid) && $past(arst_n)
    |=> out_alt_reg == $past(cfg_out_sel) && in_alt_reg == $past(cfg_in_sel))
    else $error("selector did not follow host write");
  a_cfg_locked: assert property (cfg_wr && app_running && $past(nv_valid) && $past(arst_n)
    |=> $stable(out_alt_reg) && $stable(in_alt_reg))
    else $error("selector changed while application runs");
  a_din_masked: assert property (in_alt_reg && $past(in_alt_reg) |-> din_val_reg == '0)
    else $error("plain inputs visible in frequency config");
  a_sink_float: assert property ((out_alt_reg && !src_sel[1]) [*3]
    |-> dout_oe_reg[NP-1:8] == '0)
    else $error("unused sink outputs driven");
  a_src_ground: assert property ((out_alt_reg && src_sel[1]) [*3]
    |-> dout_pin_reg[NP-1:8] == '0)
    else $error("unused source outputs not low");
  a_gnd_cut: assert property ((src_sel[0] && !gnd_ok_pin[0]) [*5]
    |-> dout_oe_reg[7:0] == '0)
    else $error("port still driven without ground");
  a_ovl_irq: assert property ($rose(ovl_pin[0]) && src_sel[0] |-> ##[1:5] ovl_irq_reg[0])
    else $error("overload interrupt missing");
  a_pat_gap: assert property (pat_irq_reg |=> !pat_irq_reg [*8])
    else $error("pattern interrupts too close");
  cover property (cfg_wr && !app_running);
  cover property (ovl_irq_reg[0]);
  cover property (pat_irq_reg);
endmodule
bind cios_top cios_asserts #(.NP(NP)) u_chk (
  .clk_sys      (clk_sys),
  .arst_n       (arst_n),
  .nv_valid     (nv_valid),
  .cfg_wr       (cfg_wr),
  .cfg_in_sel   (cfg_in_sel),
  .cfg_out_sel  (cfg_out_sel),
  .app_running  (app_running),
  .in_alt_reg   (in_alt_reg),
  .out_alt_reg  (out_alt_reg),
  .din_val_reg  (din_val_reg),
  .dout_pin_reg (dout_pin_reg),
  .dout_oe_reg  (dout_oe_reg),
  .src_sel      (src_sel),
  .gnd_ok_pin   (gnd_ok_pin),
  .ovl_pin      (ovl_pin),
  .ovl_irq_reg  (ovl_irq_reg),
  .pat_irq_reg  (pat_irq_reg)
);

// ### sim/cios_top_bench.sv
// Self-checking bench for the subdevice select block
module cios_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic nv_valid, cfg_wr, cfg_in_sel, cfg_out_sel, app_running, pat_en, pat_mode, pat_irq_reg;
  logic nv_wr_reg, nv_in_cfg, nv_out_cfg, nv_in_cfg_reg, nv_out_cfg_reg, in_alt_reg, out_alt_reg;
  logic [1:0] src_sel, port_hiz, gnd_ok_pin, ovl_pin, ovl_irq_reg;
  logic [15:0] din_pin, din_val_reg, dout_val, dout_pin_reg, dout_oe_reg, pat_cmp_mask, pat_ref, v;
  logic [31:0] pat_edge_mask, pat_status_reg;
  logic [255:0] pg_period, pg_high, fm_period_reg, fm_high_reg;
  logic [7:0] pg_start_low, pg_enable, fm_done_reg;
  int miscompares = 0;
  int total_checks = 0;
  int n, c, p, h;
  // Short event gap keeps the pattern tests brief
  cios_top #(.IRQ_GAP(10)) i_dut (.clk_sys, .arst_n, .nv_valid, .nv_in_cfg, .nv_out_cfg,
    .nv_wr_reg, .nv_in_cfg_reg, .nv_out_cfg_reg, .cfg_wr, .cfg_in_sel, .cfg_out_sel,
    .app_running, .in_alt_reg, .out_alt_reg, .din_pin, .din_val_reg, .fm_period_reg,
    .fm_high_reg, .fm_done_reg, .pg_period, .pg_high, .pg_start_low, .pg_enable, .dout_val,
    .src_sel, .port_hiz, .gnd_ok_pin, .ovl_pin, .dout_pin_reg, .dout_oe_reg, .ovl_irq_reg,
    .pat_en, .pat_mode, .pat_edge_mask, .pat_cmp_mask, .pat_ref, .pat_irq_reg,
    .pat_status_reg);
  cios_nvmem i_nv (.clk_sys, .nv_wr_reg, .nv_in_cfg_reg, .nv_out_cfg_reg, .nv_in_cfg,
    .nv_out_cfg);
  always #10 clk_sys = ~clk_sys;
  // =====
  // Helpers
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task automatic look(input int k);
    cyc(k);
    @(negedge clk_sys);
  endtask
  function automatic logic [15:0] exp_din(input logic alt, input logic [15:0] p);
    return alt ? 16'h0000 : p;
  endfunction
  // High samples in one full generator period
  function automatic int exp_hi(input logic lo, input int per, input int hi);
    return lo ? per - hi : hi;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Restart with the stored selectors offered a little after release
  task automatic rst;
    cyc(1);
    {arst_n, nv_valid} <= 2'b00;
    cyc(20);
    arst_n <= 1'b1;
    cyc(2);
    nv_valid <= 1'b1;
    look(3);
  endtask
  task automatic setcfg(input logic i, input logic o, input logic run);
    cyc(1);
    {cfg_in_sel, cfg_out_sel, app_running, cfg_wr} <= {i, o, run, 1'b1};
    cyc(1);
    {app_running, cfg_wr} <= 2'b00;
    @(negedge clk_sys);
  endtask
  // =====
  // Tests
  initial
  begin
    void'($urandom(85));
    {nv_valid, cfg_wr, cfg_in_sel, cfg_out_sel, app_running, pat_en, pat_mode} = 7'h00;
    {src_sel, port_hiz, ovl_pin, gnd_ok_pin} = 8'h03;
    {din_pin, dout_val, pat_cmp_mask, pat_ref, pat_edge_mask} = 96'h0;
    {pg_period, pg_high} = {{8{32'h0000_0010}}, {8{32'h0000_0006}}};
    {pg_start_low, pg_enable} = 16'h0fff;
    rst();
    chk({14'h0, in_alt_reg, out_alt_reg}, 16'h0000);
    setcfg(1'b1, 1'b1, 1'b1);
    chk({14'h0, in_alt_reg, out_alt_reg}, 16'h0000);
    setcfg(1'b1, 1'b1, 1'b0);
    chk({13'h0, in_alt_reg, out_alt_reg, nv_wr_reg}, 16'h0007);
    rst();
    chk({14'h0, in_alt_reg, out_alt_reg}, 16'h0003);
    cyc(1);
    din_pin <= 16'($urandom);
    look(4);
    chk(din_val_reg, exp_din(1'b1, din_pin));
    // Three periods on one channel; the first result may be stale, so skip it
    c = $urandom_range(7);
    p = $urandom_range(12, 4);
    h = $urandom_range(p - 1, 1);
    n = 0;
    for (int k = 0; k < 4 * p; k++)
    begin
      cyc(1);
      din_pin[c] <= (k < 3 * p) && (k % p < h);
      @(negedge clk_sys);
      if (k >= p)
        n += int'(fm_done_reg[c]);
    end
    chk(fm_period_reg[c*32 +: 16], 16'(p));
    chk(fm_high_reg[c*32 +: 16], 16'(h));
    chk(16'(n), 16'h0002);
    cyc(1);
    src_sel <= 2'b11;
    look(4);
    chk({dout_oe_reg[15:8], dout_pin_reg[15:8]}, 16'hff00);
    c = $urandom_range(7);
    n = 0;
    repeat (16)
    begin
      @(negedge clk_sys);
      n += int'(dout_pin_reg[c]);
    end
    v = 16'(exp_hi(pg_start_low[c], pg_period[c*32 +: 32], pg_high[c*32 +: 32]));
    chk(16'(n), v);
    setcfg(1'b0, 1'b0, 1'b0);
    cyc(1);
    {din_pin, dout_val} <= {16'($urandom), 16'($urandom)};
    look(4);
    chk(din_val_reg, exp_din(1'b0, din_pin));
    chk(dout_pin_reg, dout_val);
    chk(dout_oe_reg, 16'hffff);
    cyc(1);
    port_hiz <= 2'b10;
    look(3);
    chk(dout_oe_reg, 16'h00ff);
    cyc(1);
    {port_hiz, gnd_ok_pin} <= 4'h2;
    look(5);
    chk(dout_oe_reg, 16'hff00);
    for (int s = 0; s < 2; s++)
    begin
      cyc(1);
      {src_sel, ovl_pin, gnd_ok_pin} <= {1'b1, s[0], 4'h3};
      cyc(4);
      ovl_pin <= 2'b01;
      n = 0;
      repeat (6)
      begin
        @(negedge clk_sys);
        n += int'(ovl_irq_reg[0]);
      end
      chk(16'(n), 16'(s));
    end
    // A one-cycle pulse makes two events; the second falls in the gap
    for (int m = 0; m < 2; m++)
    begin
      v = 16'h0001 << $urandom_range(15);
      cyc(1);
      {pat_en, pat_mode, pat_ref, pat_cmp_mask, pat_edge_mask, din_pin} <=
        {1'b1, m[0], v, 16'hffff, v, v, 16'h0000};
      cyc(20);
      din_pin <= v;
      cyc(1);
      din_pin <= 16'h0000;
      n = 0;
      repeat (8)
      begin
        @(negedge clk_sys);
        n += int'(pat_irq_reg);
      end
      chk(16'(n), 16'h0001);
      chk(pat_status_reg[31:16], m ? 16'h0000 : v);
      chk(pat_status_reg[15:0], 16'h0000);
    end
    tally_and_finish();
  end
  initial
  begin
    cyc(3000);
    miscompares++;
    tally_and_finish();
  end
endmodule
